/* File: include/hsc_pkg.sv */
`default_nettype none
package hsc_pkg;
	// ********************************
	// Command codes
	// ********************************
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_CAPABILITY = 8'h19;
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_PMBUS_REV = 8'h98;
	localparam logic [7:0] CMD_MFR_ID = 8'h99;
	localparam logic [7:0] CMD_MFR_MODEL = 8'h9a;
	localparam logic [7:0] CMD_MFR_REV = 8'h9b;
	localparam logic [7:0] CMD_PMON_CONTROL = 8'hd3;
	localparam logic [7:0] CMD_DEVICE_CONFIG = 8'hd4;
	localparam logic [7:0] CMD_POWER_CYCLE = 8'hd9;
	// ********************************
	// Fields and reset values
	// ********************************
	localparam int ON_BIT = 7;
	localparam logic ON_RST = 1'b1;
	localparam int PMON_CONV_BIT = 0;
	localparam int PIN_UV = 0;
	localparam int PIN_OV = 1;
	localparam int PIN_PGS = 2;
	localparam int PIN_EN = 3;
	localparam int PIN_TIMER = 4;
	localparam int PIN_SOC = 5;
	localparam int PIN_OT = 6;
	localparam int PIN_FET = 7;
	localparam int NPINS = 8;
	localparam int FL_OC = 0;
	localparam int FL_UV = 1;
	localparam int FL_OV = 2;
	localparam int FL_TEMP = 3;
	localparam int FL_FET = 4;
	localparam int FL_SOC = 5;
	localparam int NFAULT = 6;
	localparam logic [5:0] HARD_MASK = 6'h39;
	localparam int DC_FET_EN = 0;
	localparam int DC_GPO1_MODE = 1;
	localparam int DC_GPO2_MODE = 2;
	localparam int DC_SOC_SEL = 3;
	localparam int DC_GPO1_LVL = 5;
	localparam int DC_GPO2_LVL = 6;
	localparam logic [7:0] DEVCFG_RST = 8'h01;
	localparam logic [6:0] OWN_ADDR_RST = 7'h10;
	localparam int SB_OFF = 6;
	localparam int SB_OC = 4;
	localparam int SB_UV = 3;
	localparam int SB_TEMP = 2;
	localparam int SW_INPUT = 13;
	localparam int SW_MFR = 12;
	localparam int SW_PGOOD_N = 11;
	localparam int CAP_PEC = 7;
	localparam int CAP_SPEED = 5;
	localparam int CAP_ALERT = 4;
	localparam logic [1:0] CAP_SPEED_VAL = 2'h1;
	localparam int STR_LEN = 4;
	// ********************************
	// Register offsets
	// ********************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_DEVCFG = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_OPER = 12'h00c;
	// ********************************
	// Timing
	// ********************************
	localparam int CLK_KHZ = 100000;
	localparam int RESTART_TIME_MS = 5000;
	localparam int RESTART_CYCLES = RESTART_TIME_MS * CLK_KHZ;
	localparam int SOC_BASE_CYCLES = 4;
	// ********************************
	// Types
	// ********************************
	typedef enum logic [3:0] {
		HS_OFF = 4'b0001,
		HS_ON = 4'b0010,
		HS_FAULT = 4'b0100,
		HS_CYCLE = 4'b1000
	} hs_state_t;
	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [7:0] code;
		logic [7:0] data;
		logic is_read;
		logic in_group;
	} bus_cmd_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} bus_rsp_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [7:0] data;
	} pend_t;
	typedef struct packed {
		logic [NPINS-1:0] sync1;
		logic [NPINS-1:0] sync2;
		logic [NPINS-1:0] sync3;
		logic [NPINS-1:0] pins;
		logic [6:0] own_addr;
		logic [7:0] devcfg;
		logic on_bit;
		hs_state_t st;
		logic [NFAULT-1:0] faults;
		logic [31:0] cycle_cnt;
		logic [5:0] soc_cnt;
		pend_t pend;
		bus_rsp_t rsp;
		logic conv;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} state_t;
endpackage
`default_nettype wire

/* File: rtl/hot_swap_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
module hot_swap_cmd #(
	parameter int RESTART_CNT = hsc_pkg::RESTART_CYCLES,
	parameter logic [3:0] REV_PART1 = 4'h1,
	parameter logic [3:0] REV_PART2 = 4'h1,
	parameter logic [31:0] MFR_ID_STR = 32'h4d465258, // Arbitrary value
	parameter logic [31:0] MFR_MODEL_STR = 32'h48534331, // Arbitrary value
	parameter logic [31:0] MFR_REV_STR = 32'h52455631 // Arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire hsc_pkg::bus_cmd_t bus_cmd,
	input wire logic bus_stop,
	input wire logic bus_abort,
	output hsc_pkg::bus_rsp_t bus_rsp,
	input wire logic [hsc_pkg::NPINS-1:0] pins_in,
	output logic gate_out,
	output logic supply_ok_out,
	output logic fault_out,
	output logic [1:0] gpo_out,
	output logic conv_start_out
);
	import hsc_pkg::*;

	state_t r;
	state_t n;

	// ********************************
	// Command helpers
	// ********************************

	// Executes one write command on a state copy
	function automatic state_t apply(input state_t s, input logic [7:0] code,
			input logic [7:0] data);
		state_t t;
		t = s;
		case (code)
			CMD_OPERATION: begin
				if (!s.on_bit && data[ON_BIT]) begin
					t.faults = '0;
				end
				t.on_bit = data[ON_BIT];
			end
			CMD_CLEAR_FAULTS: begin
				t.faults = '0;
			end
			CMD_DEVICE_CONFIG: begin
				t.devcfg = data;
			end
			CMD_POWER_CYCLE: begin
				if (s.st != HS_FAULT) begin
					t.st = HS_CYCLE;
					t.cycle_cnt = RESTART_CNT - 1;
				end
			end
			CMD_PMON_CONTROL: begin
				t.conv = data[PMON_CONV_BIT];
			end
			default: begin
			end
		endcase
		return t;
	endfunction

	// Picks one character of a string, index 1 is the first
	function automatic logic [7:0] str_char(input logic [31:0] str, input logic [7:0] idx);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 1; i <= STR_LEN; i++) begin
			if (idx == 8'(i)) begin
				c = str[8*(STR_LEN-i) +: 8];
			end
		end
		return c;
	endfunction

	// Status word built from live state and latched faults
	function automatic logic [15:0] status_word(input state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[SB_OFF] = (s.st != HS_ON);
		w[SB_OC] = s.faults[FL_OC] | s.faults[FL_SOC];
		w[SB_UV] = s.faults[FL_UV];
		w[SB_TEMP] = s.faults[FL_TEMP];
		w[SW_INPUT] = s.faults[FL_UV] | s.faults[FL_OV];
		w[SW_MFR] = s.faults[FL_FET];
		w[SW_PGOOD_N] = !((s.st == HS_ON) && s.pins[PIN_PGS]);
		return w;
	endfunction

	// Answer byte for a read command; index selects the byte
	function automatic logic [7:0] read_byte(input state_t s, input logic [7:0] code,
			input logic [7:0] idx);
		logic [15:0] w;
		logic [7:0] b;
		w = status_word(s);
		b = 8'h00;
		case (code)
			CMD_OPERATION: b = {s.on_bit, 7'h00};
			CMD_DEVICE_CONFIG: b = s.devcfg;
			CMD_STATUS_BYTE: b = w[7:0];
			CMD_STATUS_WORD: b = idx[0] ? w[15:8] : w[7:0];
			CMD_CAPABILITY: begin
				b[CAP_PEC] = 1'b1;
				b[CAP_SPEED +: 2] = CAP_SPEED_VAL;
				b[CAP_ALERT] = 1'b1;
			end
			CMD_PMBUS_REV: b = {REV_PART1, REV_PART2};
			CMD_MFR_ID: b = (idx == 8'h00) ? 8'(STR_LEN) : str_char(MFR_ID_STR, idx);
			CMD_MFR_MODEL: b = (idx == 8'h00) ? 8'(STR_LEN) : str_char(MFR_MODEL_STR, idx);
			CMD_MFR_REV: b = (idx == 8'h00) ? 8'(STR_LEN) : str_char(MFR_REV_STR, idx);
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// ********************************
	// Next state
	// ********************************
	logic permit;
	logic trip;
	logic [NFAULT-1:0] ev;
	logic [5:0] soc_limit;
	logic mapped;

	always_comb begin
		n = r;
		// Pin synchroniser: a change counts when stages two and three agree
		n.sync1 = pins_in;
		n.sync2 = r.sync1;
		n.sync3 = r.sync2;
		for (int i = 0; i < NPINS; i++) begin
			if (r.sync2[i] == r.sync3[i]) begin
				n.pins[i] = r.sync3[i];
			end
		end
		n.rsp.valid = 1'b0;
		n.conv = 1'b0;

		// APB slave with one wait state
		mapped = (paddr == OFS_CTRL) || (paddr == OFS_DEVCFG) ||
			(paddr == OFS_STATUS) || (paddr == OFS_OPER);
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !r.pready) begin
			n.pready = 1'b1;
			n.pslverr = !mapped;
			n.prdata = 32'h00000000;
			case (paddr)
				OFS_CTRL: n.prdata = {25'h0000000, r.own_addr};
				OFS_DEVCFG: n.prdata = {24'h000000, r.devcfg};
				OFS_STATUS: n.prdata = {12'h000, r.st, status_word(r)};
				OFS_OPER: n.prdata = {24'h000000, r.on_bit, 7'h00};
				default: n.prdata = 32'h00000000;
			endcase
			if (pwrite) begin
				case (paddr)
					OFS_CTRL: n.own_addr = pwdata[6:0];
					OFS_DEVCFG: n.devcfg = pwdata[7:0];
					OFS_OPER: n = apply(n, CMD_OPERATION, pwdata[7:0]);
					default: begin
					end
				endcase
			end
		end

		// Bus commands at our own address only
		if (bus_cmd.valid && bus_cmd.addr == r.own_addr) begin
			if (bus_cmd.in_group) begin
				if (!bus_cmd.is_read) begin
					n.pend = '{valid: 1'b1, code: bus_cmd.code, data: bus_cmd.data};
				end
			end else if (bus_cmd.is_read) begin
				n.rsp = '{valid: 1'b1, data: read_byte(r, bus_cmd.code, bus_cmd.data)};
			end else begin
				n = apply(n, bus_cmd.code, bus_cmd.data);
			end
		end
		// Stop releases the pending command, an abort throws it away
		if (bus_abort) begin
			n.pend.valid = 1'b0;
		end else if (bus_stop && r.pend.valid) begin
			n = apply(n, r.pend.code, r.pend.data);
			n.pend.valid = 1'b0;
		end

		// Severe overcurrent filter, length from the setup byte
		soc_limit = 6'(SOC_BASE_CYCLES) << r.devcfg[DC_SOC_SEL +: 2];
		if (!r.pins[PIN_SOC]) begin
			n.soc_cnt = 6'h00;
		end else if (r.soc_cnt != soc_limit) begin
			n.soc_cnt = r.soc_cnt + 6'h01;
		end

		// Fault events; a set in the same cycle as a clear wins
		ev = '0;
		ev[FL_OC] = (r.st == HS_ON) && r.pins[PIN_TIMER];
		ev[FL_UV] = !r.pins[PIN_UV];
		ev[FL_OV] = r.pins[PIN_OV];
		ev[FL_TEMP] = r.pins[PIN_OT];
		ev[FL_FET] = r.pins[PIN_FET] && r.devcfg[DC_FET_EN];
		ev[FL_SOC] = (r.soc_cnt == soc_limit) && r.pins[PIN_SOC];
		n.faults = n.faults | ev;
		trip = |(ev & HARD_MASK);

		// Hot swap state machine
		permit = r.pins[PIN_UV] && !r.pins[PIN_OV] && r.pins[PIN_EN];
		case (n.st)
			HS_OFF: begin
				if (permit && n.on_bit && !trip && !(|(n.faults & HARD_MASK))) begin
					n.st = HS_ON;
				end
			end
			HS_ON: begin
				if (trip) begin
					n.st = HS_FAULT;
				end else if (!permit || !n.on_bit) begin
					n.st = HS_OFF;
				end
			end
			HS_FAULT: begin
				if (!(|(n.faults & HARD_MASK))) begin
					n.st = HS_OFF;
				end
			end
			HS_CYCLE: begin
				if (n.cycle_cnt == 32'h00000000) begin
					n.st = HS_OFF;
				end else begin
					n.cycle_cnt = n.cycle_cnt - 32'h00000001;
				end
			end
			default: n.st = HS_OFF;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{sync1: '0, sync2: '0, sync3: '0, pins: '0, own_addr: OWN_ADDR_RST,
				devcfg: DEVCFG_RST, on_bit: ON_RST, st: HS_OFF, faults: '0,
				cycle_cnt: 32'h00000000, soc_cnt: 6'h00, pend: '0, rsp: '0,
				conv: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};
		end else begin
			r <= n;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign bus_rsp = r.rsp;
	assign gate_out = (r.st == HS_ON);
	assign supply_ok_out = (r.st == HS_ON) && r.pins[PIN_PGS];
	assign fault_out = |r.faults;
	assign conv_start_out = r.conv;
	assign gpo_out[0] = r.devcfg[DC_GPO1_MODE] ? fault_out : r.devcfg[DC_GPO1_LVL];
	assign gpo_out[1] = r.devcfg[DC_GPO2_MODE] ? fault_out : r.devcfg[DC_GPO2_LVL];

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence grp_write;
		bus_cmd.valid && bus_cmd.in_group && !bus_cmd.is_read &&
			bus_cmd.addr == r.own_addr && !bus_abort;
	endsequence
	sequence stop_ok;
		bus_stop && !bus_abort && r.pend.valid;
	endsequence

	uv_blocks_gate_a: assert property (!r.pins[PIN_UV] |=> !gate_out)
		else $error("gate on with undervoltage low");
	on_bit_low_a: assert property (!r.on_bit ##1 !r.on_bit |-> !gate_out)
		else $error("gate on while on bit is zero");
	pend_held_a: assert property (grp_write |=> r.pend.valid && !conv_start_out)
		else $error("group write not held pending");
	group_no_read_a: assert property (bus_cmd.valid && bus_cmd.in_group |=> !bus_rsp.valid)
		else $error("data returned in group");
	foreign_addr_a: assert property (bus_cmd.valid && bus_cmd.addr != r.own_addr
		&& !bus_stop && !bus_abort |=> !bus_rsp.valid && $stable(r.pend))
		else $error("foreign address answered");
	abort_drop_a: assert property (bus_abort |=> !r.pend.valid)
		else $error("pending kept after abort");
	conv_at_stop_a: assert property (stop_ok ##0 (r.pend.code == CMD_PMON_CONTROL
		&& r.pend.data[PMON_CONV_BIT]) |=> conv_start_out)
		else $error("no conversion at stop");
	fault_pin_a: assert property (r.st == HS_FAULT |-> fault_out && !supply_ok_out)
		else $error("fault without pin");
	cycle_off_a: assert property ($rose(r.st == HS_CYCLE) |-> !gate_out [*8])
		else $error("gate on during restart");
endmodule
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus host master
// ****************
module host_model (
	input wire logic pclk,
	output hsc_pkg::bus_cmd_t cmd,
	output logic stop,
	output logic abort
);
	import hsc_pkg::*;
	// Idle bus at time zero
	initial begin
		cmd = '0;
		stop = 1'h0;
		abort = 1'h0;
	end
	// One segment; idle fields show the inverse of the last value
	task send(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
		input logic rd, input logic grp);
		@(posedge pclk);
		cmd <= '{valid: 1'h1, addr: a, code: c, data: d, is_read: rd, in_group: grp};
		@(posedge pclk);
		cmd <= '{valid: 1'h0, addr: ~a, code: ~c, data: ~d, is_read: ~rd, in_group: ~grp};
	endtask
	// Single stop once every segment is written, or an abort
	task end_seg(input logic ab);
		@(posedge pclk);
		stop <= ~ab;
		abort <= ab;
		@(posedge pclk);
		stop <= 1'h0;
		abort <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench top
// ****************
module tb_top;
	import hsc_pkg::*;
	localparam int RCNT = 50;
	logic pclk = 1'h0;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready, pslverr, bus_stop, bus_abort, gate_out, supply_ok_out, fault_out, conv_start_out;
	logic [1:0] gpo_out;
	logic [7:0] pins_in;
	bus_cmd_t bus_cmd;
	bus_rsp_t bus_rsp;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	int bad_count = 0;
	int samples_checked = 0;
	int seed = 58631;
	int n, conv_cnt = 0, c0;
	logic [6:0] own;
	// Clock
	always #5 pclk = ~pclk;
	hot_swap_cmd #(.RESTART_CNT(RCNT), .MFR_ID_STR(32'h41424344)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_cmd(bus_cmd), .bus_stop(bus_stop), .bus_abort(bus_abort), .bus_rsp(bus_rsp),
		.pins_in(pins_in), .gate_out(gate_out), .supply_ok_out(supply_ok_out),
		.fault_out(fault_out), .gpo_out(gpo_out), .conv_start_out(conv_start_out));
	host_model host (.pclk(pclk), .cmd(bus_cmd), .stop(bus_stop), .abort(bus_abort));
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic lvl(input logic s, input logic e);
		check({32'h0, s}, {32'h0, e});
	endtask
	task settle();
		repeat (8) @(posedge pclk);
	endtask
	// APB transfer; the expected answer goes on the queue first
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d, 33'h0, 33'h1_0000_0000);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'h0, a, 32'h0, {1'h0, e}, {1'h1, m});
	endtask
	// Bus read; answer byte noted before the request
	task brd(input logic [7:0] c, input logic [7:0] i, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({25'h0, e & m});
		msk_q.push_back({25'h0, m});
		host.send(own, c, i, 1'h1, 1'h0);
	endtask
	// Result watcher: oldest note against each answer
	always @(posedge pclk) begin
		if (pready === 1'h1 || bus_rsp.valid === 1'h1) begin
			if (exp_q.size() == 0) begin
				check(33'h1, 33'h0);
			end else begin
				check((pready ? {pslverr, prdata} : {25'h0, bus_rsp.data}) & msk_q.pop_front(),
					exp_q.pop_front());
			end
		end
		if (conv_start_out === 1'h1) begin
			conv_cnt++;
		end
	end
	// Watchdog
	initial begin
		#(400000);
		bad_count++;
		report_and_stop();
	end
	task report_and_stop();
		$display("compared %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hard fault on one pin, then released and cleared
	task hard_fault(input logic [7:0] p, input logic e);
		pins_in <= p;
		settle();
		settle();
		lvl(fault_out, e);
		lvl(gate_out, !e);
		lvl(supply_ok_out, !e);
		pins_in <= 8'h0d;
		settle();
		host.send(own, CMD_CLEAR_FAULTS, 8'h00, 1'h0, 1'h0);
		settle();
		lvl(fault_out, 1'h0);
		lvl(gate_out, 1'h1);
	endtask
	// Main sequence
	initial begin
		presetn <= 1'h0;
		psel <= 1'h0;
		penable <= 1'h0;
		pwrite <= 1'h0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		pins_in <= 8'h00;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		pins_in <= 8'h0d;
		rd(OFS_CTRL, {25'h0, OWN_ADDR_RST}, 32'h7f);
		rd(OFS_DEVCFG, {24'h0, DEVCFG_RST}, 32'hff);
		rd(OFS_OPER, 32'h80, 32'h80);
		apb(1'h0, 12'h010, 32'h0, 33'h1_0000_0000, 33'h1_ffff_ffff);
		apb(1'h1, 12'h010, 32'(unsigned'($random(seed))), 33'h1_0000_0000, 33'h1_0000_0000);
		lvl(fault_out, 1'h1);
		wr(OFS_OPER, 32'h0);
		settle();
		lvl(gate_out, 1'h0);
		wr(OFS_OPER, 32'h80);
		settle();
		lvl(fault_out, 1'h0);
		lvl(gate_out, 1'h1);
		lvl(supply_ok_out, 1'h1);
		rd(OFS_STATUS, 32'h0002_0000, 32'h000f_0040);
		own = 7'($random(seed)) | 7'h08;
		wr(OFS_CTRL, {25'h0, own});
		host.send(own ^ 7'h01, CMD_OPERATION, 8'h00, 1'h0, 1'h1);
		host.end_seg(1'h0);
		settle();
		lvl(gate_out, 1'h1);
		host.send(own, CMD_OPERATION, 8'h00, 1'h0, 1'h1);
		host.end_seg(1'h1);
		host.end_seg(1'h0);
		settle();
		lvl(gate_out, 1'h1);
		host.send(own, CMD_OPERATION, 8'h00, 1'h0, 1'h1);
		settle();
		lvl(gate_out, 1'h1);
		host.end_seg(1'h0);
		settle();
		lvl(gate_out, 1'h0);
		rd(OFS_STATUS, 32'h0001_0040, 32'h000f_0040);
		// Supply low first, so the on request meets a settled pin
		pins_in <= 8'h0c;
		settle();
		host.send(own, CMD_OPERATION, 8'h80, 1'h0, 1'h0);
		settle();
		lvl(gate_out, 1'h0);
		pins_in <= 8'h0f;
		settle();
		lvl(gate_out, 1'h0);
		// Pins settle before the clear, else the old level re-latches
		pins_in <= 8'h0d;
		settle();
		host.send(own, CMD_CLEAR_FAULTS, 8'h00, 1'h0, 1'h0);
		settle();
		lvl(fault_out, 1'h0);
		lvl(gate_out, 1'h1);
		pins_in <= 8'h05;
		settle();
		lvl(gate_out, 1'h0);
		pins_in <= 8'h1d;
		settle();
		lvl(gate_out, 1'h0);
		lvl(fault_out, 1'h1);
		lvl(supply_ok_out, 1'h0);
		pins_in <= 8'h0d;
		settle();
		lvl(fault_out, 1'h1);
		wr(OFS_OPER, 32'h0);
		wr(OFS_OPER, 32'h80);
		settle();
		lvl(fault_out, 1'h0);
		lvl(gate_out, 1'h1);
		host.send(own, CMD_POWER_CYCLE, 8'h00, 1'h0, 1'h0);
		@(posedge pclk);
		lvl(gate_out, 1'h0);
		n = 0;
		while (gate_out !== 1'h1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		lvl(n >= RCNT && n < RCNT + 20, 1'h1);
		hard_fault(8'h8d, 1'h1);
		hard_fault(8'h4d, 1'h1);
		hard_fault(8'h2d, 1'h1);
		wr(OFS_DEVCFG, 32'h00);
		hard_fault(8'h8d, 1'h0);
		wr(OFS_DEVCFG, 32'h24);
		settle();
		check({31'h0, gpo_out}, {31'h0, 2'h1});
		host.send(own, CMD_DEVICE_CONFIG, 8'h42, 1'h0, 1'h0);
		settle();
		check({31'h0, gpo_out}, {31'h0, 2'h2});
		brd(CMD_CAPABILITY, 8'h00, 8'hb0, 8'hff);
		brd(CMD_PMBUS_REV, 8'h00, 8'h11, 8'hff);
		brd(CMD_MFR_ID, 8'h00, 8'h04, 8'hff);
		brd(CMD_MFR_ID, 8'h01, 8'h41, 8'hff);
		brd(CMD_MFR_ID, 8'h04, 8'h44, 8'hff);
		brd(CMD_STATUS_WORD, 8'h00, 8'h00, 8'h40);
		brd(CMD_STATUS_WORD, 8'h01, 8'h00, 8'h08);
		host.send(own, CMD_CAPABILITY, 8'h00, 1'h1, 1'h1);
		host.end_seg(1'h0);
		c0 = conv_cnt;
		host.send(own, CMD_PMON_CONTROL, 8'h01, 1'h0, 1'h1);
		settle();
		check(33'(conv_cnt - c0), 33'h0);
		host.end_seg(1'h0);
		settle();
		check(33'(conv_cnt - c0), 33'h1);
		settle();
		check(33'(exp_q.size()), 33'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
